// [hw/sfr_pkg.sv]
// Shared constants, types and register map of the supply fault response logic
package sfr_pkg;

	// ----------------------------------------------------------------
	// Clock and deglitch timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ         = 25_000_000;
	localparam int unsigned RAIL_GLITCH_NS = 10_000;  // Least of the 10..40 us window
	localparam int unsigned PUMP_GLITCH_NS = 15_000;  // Least of the 15..30 us window
	localparam int unsigned BAT_GLITCH_NS  = 200_000; // Typical battery deglitch

	// Least times round up to whole cycles
	function automatic int unsigned ns_to_cycles(input int unsigned ns);
		return (ns * (CLK_HZ / 1_000_000) + 999) / 1000;
	endfunction : ns_to_cycles

	localparam int unsigned RAIL_GLITCH_CYC = ns_to_cycles(RAIL_GLITCH_NS);
	localparam int unsigned PUMP_GLITCH_CYC = ns_to_cycles(PUMP_GLITCH_NS);
	localparam int unsigned BAT_GLITCH_CYC  = ns_to_cycles(BAT_GLITCH_NS);

	// ----------------------------------------------------------------
	// Comparator indices, ordered so that status registers are slices
	// ----------------------------------------------------------------
	localparam int unsigned NUM_CMP         = 18;
	localparam int unsigned CMP_CORE_UV     = 0;
	localparam int unsigned CMP_CORE_OV     = 1;
	localparam int unsigned CMP_IO_UV       = 2;
	localparam int unsigned CMP_IO_OV       = 3;
	localparam int unsigned CMP_XCVR_UV     = 4;
	localparam int unsigned CMP_XCVR_OV     = 5;
	localparam int unsigned CMP_PRE_UV      = 6;
	localparam int unsigned CMP_PRE_OV      = 7;
	localparam int unsigned CMP_PUMP_LO_UV  = 8;
	localparam int unsigned CMP_PUMP_LO_OV  = 9;
	localparam int unsigned CMP_PUMP_HI_OV  = 10;
	localparam int unsigned CMP_BAT_UV      = 11;
	localparam int unsigned CMP_BAT_OV      = 12;
	localparam int unsigned CMP_SENS_OV     = 13;
	localparam int unsigned CMP_SENS_UV     = 14;
	localparam int unsigned CMP_BG_HIGH     = 15;
	localparam int unsigned CMP_BG_LOW      = 16;
	localparam int unsigned CMP_ANALOG_INTERNAL_SUPPLY_UV     = 17;

	// Which comparators flip under emulated under- or overvoltage
	localparam logic [NUM_CMP-1:0] UV_MASK = 18'h24955;
	localparam logic [NUM_CMP-1:0] OV_MASK = 18'h036AA;

	// ----------------------------------------------------------------
	// Register map (byte addresses) and field positions
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W          = 8;
	localparam logic [7:0] OFF_MON_ONE      = 8'h00;
	localparam logic [7:0] OFF_MON_TWO      = 8'h04;
	localparam logic [7:0] OFF_SAFETY_ONE   = 8'h08;
	localparam logic [7:0] OFF_CONTROL      = 8'h0C;
	localparam logic [7:0] OFF_STATUS       = 8'h10;
	localparam int unsigned CTL_DRV_REQ     = 0;
	localparam int unsigned CTL_BAT_OV_MASK = 1;
	localparam int unsigned CTL_CORE_UNMASK = 2;
	localparam int unsigned CTL_SELF_CHECK  = 3;
	localparam int unsigned CTL_W           = 3;
	localparam logic [CTL_W-1:0] CTL_RESET  = 3'h0;
	localparam logic [2:0] WD_FAIL_LIMIT    = 3'h5;

	// Comparator self-check pattern
	localparam int unsigned SELF_TEST_TOGGLES   = 4;
	localparam int unsigned SELF_TEST_PHASE_CYC = 8;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		ST_STANDBY    = 5'h01,
		ST_RESET      = 5'h02,
		ST_DIAGNOSTIC = 5'h04,
		ST_ACTIVE     = 5'h08,
		ST_SAFE       = 5'h10
	} dev_state_e;

	typedef struct packed {
		logic standby;
		logic reset;
		logic drive;
	} fault_s;

endpackage : sfr_pkg

// [hw/glitch_filter.sv]
// Deglitch filter for one comparator output
`timescale 1ns/1ps
`default_nettype none
module glitch_filter #(
	parameter int unsigned CYCLES = 250
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Comparator side
	input  wire logic hold,
	input  wire logic raw,
	output logic      filtered
);
	localparam int unsigned CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

	typedef struct packed {
		logic [CW-1:0] count;
		logic          out;
	} flt_s;

	flt_s flt_reg;
	flt_s flt_next;

	// Output follows the input only after it stood CYCLES cycles
	always_comb begin
		flt_next = flt_reg;
		if (hold || raw == flt_reg.out) begin
			flt_next.count = '0;  // Hold freezes the flag during self-check
		end else if (flt_reg.count == LAST) begin
			flt_next.count = '0;
			flt_next.out   = raw;
		end else begin
			flt_next.count = flt_reg.count + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flt_reg <= '0;
		end else begin
			flt_reg <= flt_next;
		end
	end

	assign filtered = flt_reg.out;
endmodule : glitch_filter
`default_nettype wire

// [hw/self_check_seq.sv]
// Comparator self-check sequencer with emulated under- and overvoltage
`timescale 1ns/1ps
`default_nettype none
module self_check_seq
	import sfr_pkg::*;
(
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               rst_n,
	// Control
	input  wire logic               start,
	input  wire logic [NUM_CMP-1:0] raw,
	// Results
	output logic                    running,
	output logic                    done,
	output logic                    fail,
	// Emulation drive to the comparator inputs
	output logic                    emulate_under,
	output logic                    emulate_over
);
	localparam int unsigned PW = $clog2(SELF_TEST_PHASE_CYC + 1);
	localparam int unsigned TW = $clog2(2 * SELF_TEST_TOGGLES + 1);
	localparam logic [PW-1:0] PHASE_LAST  = PW'(SELF_TEST_PHASE_CYC - 1);
	localparam logic [TW-1:0] TOGGLE_LAST = TW'(2 * SELF_TEST_TOGGLES - 1);

	typedef struct packed {
		logic          running;
		logic          under;
		logic [PW-1:0] phase;
		logic [TW-1:0] toggles;
		logic          done;
		logic          fail;
		logic          emu_under;
		logic          emu_over;
	} seq_s;

	seq_s seq_reg;
	seq_s seq_next;
	logic [NUM_CMP-1:0] expect_v;

	// Alternate emulated UV and OV; every comparator but the two band-gap ones must follow each phase
	always_comb begin
		seq_next      = seq_reg;
		seq_next.done = 1'b0;
		expect_v      = seq_reg.under ? UV_MASK : OV_MASK;
		if (!seq_reg.running) begin
			if (start) begin
				seq_next.running = 1'b1;  // RULE7
				seq_next.under   = 1'b1;
				seq_next.phase   = '0;
				seq_next.toggles = '0;
				seq_next.fail    = 1'b0;
			end
		end else if (seq_reg.phase == PHASE_LAST) begin
			// Sample at phase end so the comparators have settled
			if (|((raw ^ expect_v) & (UV_MASK | OV_MASK))) begin
				seq_next.fail = 1'b1;  // RULE8
			end
			seq_next.phase = '0;
			seq_next.under = ~seq_reg.under;  // RULE8
			if (seq_reg.toggles == TOGGLE_LAST) begin
				seq_next.running = 1'b0;
				seq_next.done    = 1'b1;
			end else begin
				seq_next.toggles = seq_reg.toggles + 1'b1;
			end
		end else begin
			seq_next.phase = seq_reg.phase + 1'b1;
		end
		// Registered so the emulation pins come straight from flip-flops
		seq_next.emu_under = seq_next.running & seq_next.under;
		seq_next.emu_over  = seq_next.running & ~seq_next.under;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			seq_reg <= '0;
		end else begin
			seq_reg <= seq_next;
		end
	end

	// Emulation acts on comparator inputs only, never on the rails
	assign running       = seq_reg.running;
	assign done          = seq_reg.done;
	assign fail          = seq_reg.fail;
	assign emulate_under = seq_reg.emu_under;
	assign emulate_over  = seq_reg.emu_over;
endmodule : self_check_seq
`default_nettype wire

// [hw/supply_fault_response_logic.sv]
// Supply fault response: monitor flags, reactions, state control, APB slave
//
// Function
// RULE1: Start analog self-test once preregulator leaves undervoltage
// RULE2: Any self-test failure moves state to SAFE (here only in DIAGNOSTIC; in ACTIVE a failure only sets the flag)
// RULE3: Host waits for self-test before bus access
// RULE4: Drive enable from fail count and request
// RULE5: Monitor flag is one while supply out
// RULE6: Deglitch every comparator before flagging
// RULE7: Self-check at startup or host request
// RULE8: Emulate UV/OV toggles, check pattern, rails untouched
// RULE9: Battery UV: flag, STANDBY, reset, drive low
// RULE10: Battery OV: flag, RESET unless masked
// RULE11: Preregulator faults only set flags
// RULE12: Transceiver UV flag; OV flag, drive low
// RULE13: I/O UV resets; I/O OV drive low
// RULE14: Core faults react only when unmasked
// RULE15: Sensor supply faults only set flags
// RULE16: Pump high OV: flag, STANDBY, outputs low
// RULE17: Pump low OV disables regulators, STANDBY
// RULE18: Band-gap mismatch goes to STANDBY
// RULE19: Analog supply UV forces STANDBY
// RULE20: Most severe pending reaction wins
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module supply_fault_response_logic
	import sfr_pkg::*;
#(
	parameter int unsigned BAT_CYC  = BAT_GLITCH_CYC,
	parameter int unsigned RAIL_CYC = RAIL_GLITCH_CYC,
	parameter int unsigned PUMP_CYC = PUMP_GLITCH_CYC
) (
	// Clock and reset
	input  wire logic               pclk,
	input  wire logic               presetn,
	// APB slave
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [ADDR_W-1:0]  paddr,
	input  wire logic [31:0]        pwdata,
	output logic [31:0]             prdata,
	output logic                    pready,
	output logic                    pslverr,
	// Analog comparators, raw
	input  wire logic [NUM_CMP-1:0] cmp_raw,
	// Watchdog and logic self-test
	input  wire logic [2:0]         watchdog_fail_count,
	input  wire logic               logic_self_test_fail,
	// Device outputs
	output logic                    host_reset_out_n,
	output logic                    drive_enable_out,
	output logic                    main_regulator_disable,
	output dev_state_e              dev_state,
	// Comparator emulation
	output logic                    emulate_under,
	output logic                    emulate_over
);

	// ----------------------------------------------------------------
	// Deglitch filters
	// ----------------------------------------------------------------

	// Deglitch time per comparator
	function automatic int unsigned glitch_cycles(input int unsigned idx);
		if (idx == CMP_BAT_UV || idx == CMP_BAT_OV) begin
			return BAT_CYC;
		end else if (idx >= CMP_PUMP_LO_UV && idx != CMP_SENS_OV && idx != CMP_SENS_UV) begin
			return PUMP_CYC;
		end else begin
			return RAIL_CYC;
		end
	endfunction : glitch_cycles

	logic [NUM_CMP-1:0] flags;
	logic               test_running;
	logic               test_done;
	logic               test_fail;

	// Flags freeze while the self-check toggles the comparators
	for (genvar i = 0; i < NUM_CMP; i++) begin : g_flt
		glitch_filter #(
			.CYCLES (glitch_cycles(i))
		) u_flt (
			.clk      (pclk),
			.rst_n    (presetn),
			.hold     (test_running),
			.raw      (cmp_raw[i]),  // RULE6
			.filtered (flags[i])
		);
	end

	// ----------------------------------------------------------------
	// Self-check sequencer
	// ----------------------------------------------------------------
	logic start_pulse;

	self_check_seq u_seq (
		.clk           (pclk),
		.rst_n         (presetn),
		.start         (start_pulse),
		.raw           (cmp_raw),
		.running       (test_running),
		.done          (test_done),
		.fail          (test_fail),
		.emulate_under (emulate_under),
		.emulate_over  (emulate_over)
	);

	// ----------------------------------------------------------------
	// Block state
	// ----------------------------------------------------------------
	typedef struct packed {
		dev_state_e       state;
		logic             startup_pending;
		logic             start;
		logic             self_fail;
		logic [CTL_W-1:0] ctl;
		logic [31:0]      rdata;
		logic             ready;
		logic             slverr;
		logic             host_reset_n;
		logic             drive_en;
		logic             reg_off;
	} blk_s;

	blk_s   blk_reg;
	blk_s   blk_next;
	fault_s fault;

	// Register read mux; unmapped addresses answer zero
	function automatic logic [31:0] read_word(
		input logic [ADDR_W-1:0]  addr,
		input logic [NUM_CMP-1:0] f,
		input blk_s               b,
		input logic               run,
		input logic [2:0]         wd
	);
		logic [31:0] w;
		w = 32'h0;
		case (addr)
			OFF_MON_ONE:    w[7:2] = {f[CMP_BAT_OV:CMP_PUMP_LO_UV], f[CMP_ANALOG_INTERNAL_SUPPLY_UV]};  // RULE5
			OFF_MON_TWO:    w[7:0] = f[CMP_PRE_OV:CMP_CORE_UV];  // RULE5 RULE11
			OFF_SAFETY_ONE: w[5:4] = f[CMP_SENS_UV:CMP_SENS_OV];  // RULE15
			OFF_CONTROL:    w[CTL_W-1:0] = b.ctl;
			OFF_STATUS:     w[11:0] = {wd, f[CMP_BG_LOW], f[CMP_BG_HIGH],
				b.self_fail, run, b.state};
			default:        w = 32'h0;
		endcase
		return w;
	endfunction : read_word

	// Mapped offsets
	function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
		return addr == OFF_MON_ONE || addr == OFF_MON_TWO || addr == OFF_SAFETY_ONE
			|| addr == OFF_CONTROL || addr == OFF_STATUS;
	endfunction : is_mapped

	// ----------------------------------------------------------------
	// Fault classification
	// ----------------------------------------------------------------

	// Preregulator, sensor and pump-low UV only flag; they take no part here
	always_comb begin
		fault.standby = flags[CMP_BAT_UV]  // RULE9
			| flags[CMP_PUMP_HI_OV]  // RULE16
			| flags[CMP_PUMP_LO_OV]  // RULE17
			| flags[CMP_BG_HIGH] | flags[CMP_BG_LOW]  // RULE18
			| flags[CMP_ANALOG_INTERNAL_SUPPLY_UV];  // RULE19
		fault.reset = flags[CMP_IO_UV]  // RULE13
			| (flags[CMP_BAT_OV] & ~blk_reg.ctl[CTL_BAT_OV_MASK])  // RULE10
			| (flags[CMP_CORE_UV] & blk_reg.ctl[CTL_CORE_UNMASK]);  // RULE14
		fault.drive = flags[CMP_XCVR_OV]  // RULE12
			| flags[CMP_IO_OV]  // RULE13
			| (flags[CMP_CORE_OV] & blk_reg.ctl[CTL_CORE_UNMASK]);  // RULE14
	end

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	logic setup;
	logic wr_access;
	logic host_check;

	always_comb begin
		blk_next       = blk_reg;
		blk_next.start = 1'b0;
		setup          = psel & ~penable;
		wr_access      = psel & penable & pwrite & blk_reg.ready;
		host_check     = 1'b0;

		// APB: decode in setup, answer one cycle later with pready
		blk_next.ready  = setup;
		blk_next.slverr = setup & ~is_mapped(paddr);
		blk_next.rdata  = 32'h0;
		if (setup && !pwrite) begin
			blk_next.rdata = read_word(paddr, flags, blk_reg, test_running,
				watchdog_fail_count);
		end
		if (wr_access && paddr == OFF_CONTROL) begin
			blk_next.ctl = pwdata[CTL_W-1:0];
			// Host self-check only in DIAGNOSTIC or ACTIVE
			host_check = pwdata[CTL_SELF_CHECK]
				& (blk_reg.state == ST_DIAGNOSTIC || blk_reg.state == ST_ACTIVE);  // RULE7
		end

		// Self-check launch: once at power-up, or on host request
		if (!test_running && !blk_reg.start) begin
			if (blk_reg.startup_pending && !flags[CMP_PRE_UV]) begin
				blk_next.start           = 1'b1;  // RULE1
				blk_next.startup_pending = 1'b0;
			end else if (host_check) begin
				blk_next.start = 1'b1;  // RULE7
			end
		end

		// Failure flag stays until a passing run
		if (test_done) begin
			blk_next.self_fail = test_fail;
		end

		// State controller
		case (blk_reg.state)
			ST_STANDBY: begin
				if (!fault.standby) begin
					blk_next.state = ST_RESET;
				end
			end
			ST_RESET: begin
				if (!fault.reset && !blk_reg.startup_pending) begin
					blk_next.state = ST_DIAGNOSTIC;
				end else if (blk_reg.startup_pending && !flags[CMP_PRE_UV]) begin
					blk_next.state = ST_DIAGNOSTIC;
				end
			end
			ST_DIAGNOSTIC: begin
				if (test_done && (test_fail || logic_self_test_fail)) begin
					blk_next.state = ST_SAFE;  // RULE2
				end else if (!test_running && !blk_reg.start) begin
					blk_next.state = ST_ACTIVE;
				end
			end
			ST_ACTIVE: begin
				// A failure in ACTIVE only sets the flag
				blk_next.state = ST_ACTIVE;
			end
			ST_SAFE: begin
				blk_next.state = ST_SAFE;
			end
			default: begin
				blk_next.state = ST_STANDBY;
			end
		endcase

		// Severity order: STANDBY over RESET over drive-only
		if (fault.standby) begin
			blk_next.state = ST_STANDBY;  // RULE20
		end else if (fault.reset && blk_reg.state != ST_STANDBY) begin
			blk_next.state = ST_RESET;  // RULE20
		end

		// Host reset low in RESET and STANDBY
		blk_next.host_reset_n = (blk_next.state != ST_RESET)
			&& (blk_next.state != ST_STANDBY);  // RULE9

		// Drive enable: request, failure count, state and no pending fault
		blk_next.drive_en = blk_reg.ctl[CTL_DRV_REQ]
			&& (watchdog_fail_count < WD_FAIL_LIMIT)  // RULE4
			&& blk_next.state == ST_ACTIVE
			&& !test_running && !blk_reg.start
			&& !fault.drive && !fault.reset && !fault.standby;  // RULE20

		// Main regulators off while the low pump rail is over
		blk_next.reg_off = flags[CMP_PUMP_LO_OV];  // RULE17
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------

	// Start in RESET with the power-up self-check armed
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			blk_reg                 <= '0;
			blk_reg.state           <= ST_RESET;
			blk_reg.startup_pending <= 1'b1;
			blk_reg.ctl             <= CTL_RESET;
		end else begin
			blk_reg <= blk_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs, all from flip-flops
	// ----------------------------------------------------------------
	assign start_pulse            = blk_reg.start;
	assign prdata                 = blk_reg.rdata;
	assign pready                 = blk_reg.ready;
	assign pslverr                = blk_reg.slverr;
	assign host_reset_out_n       = blk_reg.host_reset_n;
	assign drive_enable_out       = blk_reg.drive_en;
	assign main_regulator_disable = blk_reg.reg_off;
	assign dev_state              = blk_reg.state;

endmodule : supply_fault_response_logic
`default_nettype wire

// [bench/sfr_checker_assertions.sv]
// Port-level assertions for the supply fault response logic
`timescale 1ns/1ps
`default_nettype none
module sfr_checker
	import sfr_pkg::*;
#(
	parameter int unsigned BAT_CYC = BAT_GLITCH_CYC
) (
	// Clock and reset
	input wire logic               pclk,
	input wire logic               presetn,
	// Bus handshake
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pready,
	// Monitor inputs
	input wire logic [NUM_CMP-1:0] cmp_raw,
	input wire logic [2:0]         watchdog_fail_count,
	// Device outputs
	input wire logic               host_reset_out_n,
	input wire logic               drive_enable_out,
	input wire logic               main_regulator_disable,
	input wire dev_state_e         dev_state,
	input wire logic               emulate_under,
	input wire logic               emulate_over
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// ----------
	// Battery dwell counter
	// ----------
	// Emulation restarts it, since the filters freeze during a self-check
	logic [7:0] bat_cnt;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bat_cnt <= 8'h00;
		end else if (!cmp_raw[CMP_BAT_UV] || emulate_under || emulate_over) begin
			bat_cnt <= 8'h00;
		end else if (bat_cnt != 8'hFF) begin
			bat_cnt <= bat_cnt + 8'h01;
		end
	end

	// ----------
	// Assertions
	// ----------
	a_bat_uv_standby:
		assert property (bat_cnt == 8'(BAT_CYC + 4) |-> dev_state == ST_STANDBY)
		else $error("battery undervoltage did not reach standby");
	a_drive_count:
		assert property ($past(watchdog_fail_count) >= WD_FAIL_LIMIT
			&& $past(watchdog_fail_count, 2) >= WD_FAIL_LIMIT |-> !drive_enable_out)
		else $error("drive enabled with high fail count");
	a_standby_outs:
		assert property (dev_state == ST_STANDBY |-> !host_reset_out_n && !drive_enable_out)
		else $error("standby with reset or drive released");
	a_reset_outs:
		assert property (dev_state == ST_RESET |-> !host_reset_out_n && !drive_enable_out)
		else $error("reset state with reset or drive released");
	a_safe_drive:
		assert property (dev_state == ST_SAFE |-> !drive_enable_out)
		else $error("drive enabled in safe state");
	a_emul_apart:
		assert property (!(emulate_under && emulate_over))
		else $error("both emulations active");
	a_emul_drive:
		assert property (emulate_under || emulate_over |-> !drive_enable_out)
		else $error("drive enabled during self-check");
	a_regdis_standby:
		assert property (main_regulator_disable |-> dev_state == ST_STANDBY)
		else $error("regulators disabled outside standby");
	a_pump_glitch:
		assert property ($rose(main_regulator_disable) |-> $past(cmp_raw[CMP_PUMP_LO_OV], 2)
			&& $past(cmp_raw[CMP_PUMP_LO_OV], 6))
		else $error("pump fault reacted before its deglitch");
	a_bus_answer:
		assert property (psel && !penable |=> pready)
		else $error("bus access not answered in first access cycle");
endmodule : sfr_checker

bind supply_fault_response_logic sfr_checker #(.BAT_CYC(BAT_CYC)) sfr_checker_inst (.*);
`default_nettype wire

// [bench/host_master.sv]
// Host microcontroller model: bus master reading and writing the block
`timescale 1ns/1ps
`default_nettype none
module host_master
	import sfr_pkg::*;
(
	// Clock
	input  wire logic              pclk,
	// Request
	output logic                   psel,
	output logic                   penable,
	output logic                   pwrite,
	output logic [ADDR_W-1:0]      paddr,
	output logic [31:0]            pwdata,
	// Answer
	input  wire logic [31:0]       prdata,
	input  wire logic              pready,
	input  wire logic              pslverr
);
	// Idle bus at time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
	end

	// One transfer, held until pready is sampled high
	task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the bench watchdog ends a wait that never gets an answer
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		// Released address and data lines never show the last value
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
	endtask : xfer
endmodule : host_master
`default_nettype wire

// [bench/supply_fault_response_logic_tb_top.sv]
// Self-checking bench for the supply fault response logic
`timescale 1ns/1ps
`default_nettype none
module supply_fault_response_logic_tb_top;
	import sfr_pkg::*;
	// ----------
	// Wiring and tables
	// ----------
	localparam int BC = 20;
	localparam int SC = 2 * SELF_TEST_TOGGLES * SELF_TEST_PHASE_CYC;
	logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic               logic_self_test_fail, host_reset_out_n, drive_enable_out;
	logic               main_regulator_disable, emulate_under, emulate_over;
	logic [ADDR_W-1:0]  paddr;
	logic [31:0]        pwdata, prdata, q;
	logic [NUM_CMP-1:0] cmp_raw, fault, stuck;
	logic [2:0]         watchdog_fail_count;
	dev_state_e         dev_state, es;
	int                 error_cnt, comparisons, emu_cyc, e0;
	// Fault model: comparator, register, bit, control, reaction (1 drive 2 reset 3 standby)
	int tc[21] = '{0, 1, 0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 12, 13, 14, 15, 16, 17};
	int ta[21] = '{4, 4, 4, 4, 4, 4, 4, 4, 4, 4, 0, 0, 0, 0, 0, 0, 8, 8, 16, 16, 0};
	int tbit[21] = '{0, 1, 0, 1, 2, 3, 4, 5, 6, 7, 3, 4, 5, 6, 7, 7, 4, 5, 7, 8, 2};
	int tk[21] = '{1, 1, 5, 5, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 3, 1, 1, 1, 1, 1};
	int tr[21] = '{0, 0, 2, 1, 2, 1, 0, 1, 0, 0, 0, 3, 3, 3, 2, 0, 0, 0, 3, 3, 3};

	// Comparators: emulation trips them while the rails stay put
	assign cmp_raw = (fault | ({NUM_CMP{emulate_under}} & UV_MASK)
		| ({NUM_CMP{emulate_over}} & OV_MASK)) & ~stuck;

	supply_fault_response_logic #(.BAT_CYC(BC), .RAIL_CYC(5), .PUMP_CYC(6))
		supply_fault_response_logic_inst (.*);
	host_master host_master_inst (.*);

	// Clock and emulation cycle count
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	always @(posedge pclk) emu_cyc <= emu_cyc + int'(emulate_under | emulate_over);

	// ----------
	// Tasks
	// ----------
	task automatic check(input logic [32:0] got, input logic [32:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic rw(input logic w, input logic [7:0] a, input int d);
		host_master_inst.xfer(w, a, 32'(d), q, e);
	endtask : rw
	task automatic wait_st(input dev_state_e s);
		int n;
		n = 0;
		while (dev_state !== s && n < 600) begin
			@(posedge pclk);
			n++;
		end
		check(33'(dev_state), 33'(s));
	endtask : wait_st
	task automatic do_reset;
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
	endtask : do_reset
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : tally_and_finish

	// ----------
	// Sequence
	// ----------
	initial begin
		presetn = 1'b0;
		fault = '0;
		stuck = '0;
		logic_self_test_fail = 1'b0;
		watchdog_fail_count = 3'h0;
		error_cnt = 0;
		comparisons = 0;
		emu_cyc = 0;
		void'($urandom(66));
		// Power-up self-check; the host keeps off the bus until ACTIVE
		do_reset();
		wait_st(ST_ACTIVE);
		check(emu_cyc, SC);
		rw(0, OFF_STATUS, 0);
		check(q[6:0], {2'h0, ST_ACTIVE});
		$display("power-up test done");
		// Control, read-only monitor, unmapped place, drive gating
		rw(1, OFF_CONTROL, 7);
		rw(0, OFF_CONTROL, 0);
		check(q, 7);
		rw(1, OFF_MON_ONE, 255);
		rw(0, OFF_MON_ONE, 0);
		check({e, q}, 0);
		rw(0, 8'h14, 0);
		check({e, q}, 33'h100000000);
		for (int k = 0; k < 6; k++) begin
			watchdog_fail_count <= (k < 2) ? 3'(4 + k) : 3'($urandom % 8);
			rw(1, OFF_CONTROL, 1);
			repeat (3) @(posedge pclk);
			check(drive_enable_out, watchdog_fail_count < WD_FAIL_LIMIT);
		end
		watchdog_fail_count <= 3'h0;
		$display("register test done");
		// Each fault: a glitch below the filter, then held, then released
		foreach (tc[i]) begin
			rw(1, OFF_CONTROL, tk[i]);
			fault[tc[i]] <= 1'b1;
			repeat (1 + $urandom % 4) @(posedge pclk);
			fault[tc[i]] <= 1'b0;
			rw(0, 8'(ta[i]), 0);
			check(q[tbit[i]], 0);
			fault[tc[i]] <= 1'b1;
			repeat (BC + 3) @(posedge pclk);
			rw(0, 8'(ta[i]), 0);
			check(q[tbit[i]], 1);
			es = tr[i] == 3 ? ST_STANDBY : tr[i] == 2 ? ST_RESET : ST_ACTIVE;
			check({host_reset_out_n, drive_enable_out, main_regulator_disable, dev_state},
				{tr[i] < 2, tr[i] == 0, tc[i] == 9, es});
			fault[tc[i]] <= 1'b0;
			repeat (BC + 3) @(posedge pclk);
			wait_st(ST_ACTIVE);
			rw(0, 8'(ta[i]), 0);
			check(q[tbit[i]], 0);
		end
		$display("fault test done");
		// Host-requested self-check, passing and then with a stuck comparator
		for (int k = 0; k < 2; k++) begin
			stuck[CMP_IO_UV] <= k[0];
			e0 = emu_cyc;
			rw(1, OFF_CONTROL, 9);
			repeat (SC + 16) @(posedge pclk);
			check(emu_cyc - e0, SC);
			rw(0, OFF_STATUS, 0);
			check(q[6:0], {k[0], 1'b0, ST_ACTIVE});
		end
		$display("requested self-check test done");
		// Power-up failure of either self-test
		for (int k = 0; k < 2; k++) begin
			stuck[CMP_IO_UV] <= k == 0;
			logic_self_test_fail <= k == 1;
			do_reset();
			wait_st(ST_SAFE);
		end
		$display("safe state test done");
		tally_and_finish();
	end

	// Cut a hang short
	initial begin
		repeat (40000) @(posedge pclk);
		error_cnt++;
		tally_and_finish();
	end
endmodule : supply_fault_response_logic_tb_top
`default_nettype wire
